// [rtl/dct_top.sv]
// dual 8-bit / cascaded 16-bit counter timer with apb register access
`timescale 1ns/1ps
`default_nettype none
module dct_top
(
   // clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              rst_in,
   // apb slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [11:0]       paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // clock and enable sources
   input  wire dct_pkg::dct_src_s src_in,
   // outputs
   output logic                   irq_out,
   output logic                   comparator_select_out,
   output logic      [5:0]        port_data_out,
   output logic      [5:0]        port_oe_n_out
);
   // ------------------------------------------------------------
   // synchronisers and edge detect
   // ------------------------------------------------------------
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] sync3_q;
   logic [3:0] src_raw;
   assign src_raw = {src_in.timer_input_pin, src_in.comparator_signal,
                     src_in.aux_clk, src_in.main_clk};
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         sync3_q <= 4'h0;
      end
      else
      begin
         // the main clock is the system clock domain's own tick source
         sync1_q <= src_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end
   logic [3:0] rise;
   assign rise = sync2_q & ~sync3_q;
   logic main_tick;
   logic aux_tick;
   logic cmp_tick;
   logic pin_tick;
   logic cmp_lvl;
   logic pin_lvl;
   // main clock counts every system cycle so reads stay synchronous
   assign main_tick = 1'b1;
   assign aux_tick = rise[1];
   assign cmp_tick = rise[2];
   assign pin_tick = rise[3];
   assign cmp_lvl = sync2_q[2];
   assign pin_lvl = sync2_q[3];
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] low_counter_q;
   logic [7:0] high_counter_q;
   logic       enable_a_q;
   logic       enable_b_q;
   logic       low_clk_sel0_q;
   logic       low_clk_sel1_q;
   logic       high_clk_sel0_q;
   logic       high_clk_sel1_q;
   logic       low_carry_flag_q;
   logic       high_carry_flag_q;
   logic       enable_loss_flag_q;
   logic       comparator_on_q;
   logic       width_select_q;
   logic [5:0] data_out_q;
   logic [5:0] data_oe_q;
   logic       periph_irq_enable_q;
   logic wr;
   assign wr = psel_in & penable_in & pwrite_in;
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction
   logic mapped;
   assign mapped = hit(paddr_in, dct_pkg::ADDR_CONTROL) | hit(paddr_in, dct_pkg::ADDR_LOW_CNT)
                 | hit(paddr_in, dct_pkg::ADDR_HIGH_CNT) | hit(paddr_in, dct_pkg::ADDR_DATA)
                 | hit(paddr_in, dct_pkg::ADDR_ENABLE) | hit(paddr_in, dct_pkg::ADDR_IRQ_EN);
   logic wr_ctl;
   logic wr_lcnt;
   logic wr_hcnt;
   logic wr_dat;
   logic wr_ena;
   logic wr_ie;
   assign wr_ctl = wr & hit(paddr_in, dct_pkg::ADDR_CONTROL);
   assign wr_lcnt = wr & hit(paddr_in, dct_pkg::ADDR_LOW_CNT);
   assign wr_hcnt = wr & hit(paddr_in, dct_pkg::ADDR_HIGH_CNT);
   assign wr_dat = wr & hit(paddr_in, dct_pkg::ADDR_DATA);
   assign wr_ena = wr & hit(paddr_in, dct_pkg::ADDR_ENABLE);
   assign wr_ie = wr & hit(paddr_in, dct_pkg::ADDR_IRQ_EN);
   // ------------------------------------------------------------
   // enable and clock selection
   // ------------------------------------------------------------
   logic low_count_enable;
   always_comb
   begin
      case ({enable_b_q, enable_a_q})
         2'b00:   low_count_enable = 1'b0;
         2'b01:   low_count_enable = 1'b1;
         2'b10:   low_count_enable = pin_lvl;
         default: low_count_enable = cmp_lvl;
      endcase
   end
   logic low_count_clock;
   always_comb
   begin
      case ({low_clk_sel1_q, low_clk_sel0_q})
         2'b00:   low_count_clock = cmp_tick;
         2'b01:   low_count_clock = aux_tick;
         default: low_count_clock = main_tick;
      endcase
   end
   logic high_own_clock;
   always_comb
   begin
      case ({high_clk_sel1_q, high_clk_sel0_q})
         2'b00:   high_own_clock = pin_tick;
         2'b01:   high_own_clock = aux_tick;
         default: high_own_clock = main_tick;
      endcase
   end
   logic high_count_clock;
   logic low_carry;
   logic high_count_enable;
   logic high_carry;
   // cascade: shared clock, low carry gates the high byte
   assign high_count_clock = width_select_q ? low_count_clock : high_own_clock;
   assign low_carry = (low_counter_q == dct_pkg::CNT_FULL);
   assign high_count_enable = width_select_q ? (low_carry & low_count_enable) : 1'b1;
   assign high_carry = (high_counter_q == dct_pkg::CNT_FULL) & high_count_enable;
   logic low_step;
   logic high_step;
   assign low_step = low_count_clock & low_count_enable;
   assign high_step = high_count_clock & high_count_enable;
   // carry fires exactly when a step wraps the full count
   logic low_wrap;
   logic high_wrap;
   assign low_wrap = low_step & low_carry & ~wr_lcnt;
   assign high_wrap = high_step & high_carry & ~wr_hcnt;
   // external loss: a falling edge of the selected source level itself, so a change of
   // the enable bits (even from pin to comparator) can never raise the flag
   logic ext_src;
   logic loss_evt;
   assign ext_src = enable_b_q & ~wr_ctl;
   assign loss_evt = ext_src & (enable_a_q ? (sync3_q[2] & ~sync2_q[2])
                                           : (sync3_q[3] & ~sync2_q[3]));
   // ------------------------------------------------------------
   // counters
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         low_counter_q <= dct_pkg::BYTE_ZERO;
      else if (wr_lcnt)
         low_counter_q <= pwdata_in[7:0];
      else if (low_step)
         low_counter_q <= low_counter_q + dct_pkg::CNT_ONE;
   end
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         high_counter_q <= dct_pkg::BYTE_ZERO;
      else if (wr_hcnt)
         high_counter_q <= pwdata_in[7:0];
      else if (high_step)
         high_counter_q <= high_counter_q + dct_pkg::CNT_ONE;
   end
   // ------------------------------------------------------------
   // control register and flags (carry set wins over clear; a control write wins over a loss edge)
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         enable_a_q <= 1'b0;
         enable_b_q <= 1'b0;
         low_clk_sel0_q <= 1'b0;
         low_clk_sel1_q <= 1'b0;
      end
      else if (wr_ctl)
      begin
         enable_a_q <= pwdata_in[dct_pkg::CTL_ENA];
         enable_b_q <= pwdata_in[dct_pkg::CTL_ENB];
         low_clk_sel0_q <= pwdata_in[dct_pkg::CTL_SEL0];
         low_clk_sel1_q <= pwdata_in[dct_pkg::CTL_SEL1];
      end
   end
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         low_carry_flag_q <= 1'b0;
      else if (low_wrap & ~width_select_q)
         low_carry_flag_q <= 1'b1;
      else if (wr_ctl)
         low_carry_flag_q <= pwdata_in[dct_pkg::CTL_LCF];
   end
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         high_carry_flag_q <= 1'b0;
      else if (high_wrap)
         high_carry_flag_q <= 1'b1;
      else if (wr_ctl)
         high_carry_flag_q <= pwdata_in[dct_pkg::CTL_HCF];
   end
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         enable_loss_flag_q <= 1'b0;
      else if (loss_evt)
         enable_loss_flag_q <= 1'b1;
      else if (wr_ctl)
         enable_loss_flag_q <= pwdata_in[dct_pkg::CTL_LOSS];
   end

   // ------------------------------------------------------------
   // data, enable and interrupt enable registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         data_out_q <= dct_pkg::DAT_OUT_RST;
         width_select_q <= 1'b0;
         comparator_on_q <= 1'b0;
      end
      else if (wr_dat)
      begin
         data_out_q <= pwdata_in[5:0];
         width_select_q <= pwdata_in[dct_pkg::DAT_WIDTH];
         // sticky: only reset returns the pin to its segment use
         comparator_on_q <= comparator_on_q | pwdata_in[dct_pkg::DAT_CMP_ON];
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         data_oe_q <= dct_pkg::ENR_RST[5:0];
         high_clk_sel0_q <= dct_pkg::ENR_RST[dct_pkg::ENR_HSEL0];
         high_clk_sel1_q <= dct_pkg::ENR_RST[dct_pkg::ENR_HSEL1];
      end
      else if (wr_ena)
      begin
         data_oe_q <= pwdata_in[5:0];
         high_clk_sel0_q <= pwdata_in[dct_pkg::ENR_HSEL0];
         high_clk_sel1_q <= pwdata_in[dct_pkg::ENR_HSEL1];
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         periph_irq_enable_q <= 1'b0;
      else if (wr_ie)
         periph_irq_enable_q <= pwdata_in[0];
   end

   // ------------------------------------------------------------
   // read mux and outputs
   // ------------------------------------------------------------
   logic [7:0] ctl_rd;
   assign ctl_rd = {low_clk_sel1_q, low_clk_sel0_q, enable_b_q, enable_a_q,
                    low_count_enable, high_carry_flag_q, low_carry_flag_q,
                    enable_loss_flag_q};

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         prdata_out <= 32'h0000_0000;
      else if (psel_in & ~penable_in & ~pwrite_in)
      begin
         // reads only sample state, so counting is never disturbed
         case (1'b1)
            hit(paddr_in, dct_pkg::ADDR_CONTROL):  prdata_out <= {24'h00_0000, ctl_rd};
            hit(paddr_in, dct_pkg::ADDR_LOW_CNT):  prdata_out <= {24'h00_0000, low_counter_q};
            hit(paddr_in, dct_pkg::ADDR_HIGH_CNT): prdata_out <= {24'h00_0000, high_counter_q};
            hit(paddr_in, dct_pkg::ADDR_DATA):
               prdata_out <= {24'h00_0000, width_select_q, comparator_on_q, data_out_q};
            hit(paddr_in, dct_pkg::ADDR_ENABLE):
               prdata_out <= {24'h00_0000, high_clk_sel1_q, high_clk_sel0_q, data_oe_q};
            hit(paddr_in, dct_pkg::ADDR_IRQ_EN):
               prdata_out <= {31'h0000_0000, periph_irq_enable_q};
            default: prdata_out <= 32'h0000_0000;
         endcase
      end
   end

   assign pready_out = 1'b1;
   assign pslverr_out = psel_in & penable_in & ~mapped;
   // low flag still requests in 16-bit mode when software sets it
   assign irq_out = periph_irq_enable_q
                  & (low_carry_flag_q | high_carry_flag_q | enable_loss_flag_q);
   assign comparator_select_out = comparator_on_q;
   assign port_data_out = data_out_q;
   assign port_oe_n_out = ~data_oe_q;
   logic unused;
   assign unused = &{rise[0], sync2_q[1:0], 1'b0};
endmodule
`default_nettype wire

// [rtl/dct_pkg.sv]
// package: register map, field positions and types of the dual counter timer
package dct_pkg;
   // register indices; each register sits at four times its index on the apb bus
   localparam logic [7:0] IDX_CONTROL = 8'h4B;
   localparam logic [7:0] IDX_LOW_CNT = 8'h4C;
   localparam logic [7:0] IDX_HIGH_CNT = 8'h4D;
   localparam logic [7:0] IDX_DATA = 8'h4E;
   localparam logic [7:0] IDX_ENABLE = 8'h4F;
   localparam logic [7:0] IDX_IRQ_EN = 8'h50;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'b00, IDX_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_LOW_CNT = {2'b00, IDX_LOW_CNT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_HIGH_CNT = {2'b00, IDX_HIGH_CNT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_DATA = {2'b00, IDX_DATA, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = {2'b00, IDX_ENABLE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = {2'b00, IDX_IRQ_EN, 2'b00};
   // control register fields
   localparam int CTL_LOSS = 0;
   localparam int CTL_LCF = 1;
   localparam int CTL_HCF = 2;
   localparam int CTL_EN = 3;
   localparam int CTL_ENA = 4;
   localparam int CTL_ENB = 5;
   localparam int CTL_SEL0 = 6;
   localparam int CTL_SEL1 = 7;
   // data register fields
   localparam int DAT_CMP_ON = 6;
   localparam int DAT_WIDTH = 7;
   localparam logic [5:0] DAT_OUT_RST = 6'h00;
   // enable register fields
   localparam int ENR_HSEL0 = 6;
   localparam int ENR_HSEL1 = 7;
   localparam logic [7:0] ENR_RST = 8'hC0;
   localparam logic [7:0] CNT_FULL = 8'hFF;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef struct packed {
      logic main_clk;
      logic aux_clk;
      logic comparator_signal;
      logic timer_input_pin;
   } dct_src_s;
endpackage

// [tb/dct_top_props.sv]
// checker: port-level relations of the dual counter timer
`timescale 1ns/1ps
`default_nettype none
module dct_top_props
(
   // clock and reset
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   // apb
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // outputs
   input wire logic        irq_out,
   input wire logic        comparator_select_out,
   input wire logic [5:0]  port_oe_n_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   logic acc;
   logic wr_dat;
   logic wr_irq;
   logic mapped;
   assign acc = psel_in & penable_in;
   assign wr_dat = acc & pwrite_in & (paddr_in == dct_pkg::ADDR_DATA);
   assign wr_irq = acc & pwrite_in & (paddr_in == dct_pkg::ADDR_IRQ_EN);
   assign mapped = paddr_in inside {dct_pkg::ADDR_CONTROL, dct_pkg::ADDR_LOW_CNT,
      dct_pkg::ADDR_HIGH_CNT, dct_pkg::ADDR_DATA, dct_pkg::ADDR_ENABLE, dct_pkg::ADDR_IRQ_EN};
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_cmp_set;
      wr_dat && pwdata_in[dct_pkg::DAT_CMP_ON] |=> comparator_select_out;
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("comparator select not set");
   property p_cmp_sticky;
      comparator_select_out |=> comparator_select_out;
   endproperty
   a_cmp_sticky: assert property (p_cmp_sticky) else $error("comparator select fell");
   property p_cmp_off;
      !comparator_select_out && !(wr_dat && pwdata_in[6]) |=> !comparator_select_out;
   endproperty
   a_cmp_off: assert property (p_cmp_off) else $error("comparator select rose alone");
   property p_rst_val;
      $fell(rst_in) |-> !irq_out && !comparator_select_out && port_oe_n_out == 6'h3F
         && prdata_out == 32'h0000_0000;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("bad value after reset");
   property p_irq_off;
      wr_irq && !pwdata_in[0] |=> !irq_out;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_irq_hold;
      irq_out && !(acc && pwrite_in) |=> irq_out;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");
   property p_rdy;
      psel_in |-> pready_out;
   endproperty
   a_rdy: assert property (p_rdy) else $error("access not ready");
   property p_err;
      acc |-> pslverr_out == !mapped;
   endproperty
   a_err: assert property (p_err) else $error("bad slave error");
   c_cmp: cover property (wr_dat && pwdata_in[6]);
   c_irq: cover property ($rose(irq_out));
   c_err: cover property (acc && !mapped);
endmodule
bind dct_top dct_top_props u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .irq_out(irq_out),
   .comparator_select_out(comparator_select_out), .port_oe_n_out(port_oe_n_out));
`default_nettype wire

// [tb/dct_src_model.sv]
// model of the aux clock, comparator and timer input pin sources
`timescale 1ns/1ps
`default_nettype none
module dct_src_model
(
   input  wire logic             sys_clk_in,
   output var dct_pkg::dct_src_s src_out
);
   logic aux_q = 1'b0;
   logic cmp_q = 1'b0;
   logic pin_q = 1'b0;
   // main clock is the system clock; slow sources rest low between pulses
   always_comb src_out = '{main_clk: sys_clk_in, aux_clk: aux_q,
      comparator_signal: cmp_q, timer_input_pin: pin_q};
   task automatic set_src(input int which, input logic v);
      case (which)
         0: aux_q <= v;
         1: cmp_q <= v;
         default: pin_q <= v;
      endcase
   endtask
   // edges far slower than the sampling clock, unrelated to reads
   task automatic pulse(input int which, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge sys_clk_in);
         set_src(which, 1'b1);
         repeat (4) @(posedge sys_clk_in);
         set_src(which, 1'b0);
         repeat (4) @(posedge sys_clk_in);
      end
   endtask
endmodule
`default_nettype wire

// [tb/dct_top_tb.sv]
// testbench: apb register sequences against the dual counter timer
`timescale 1ns/1ps
`default_nettype none
module dct_top_tb;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              psel = 1'b0;
   logic              pen = 1'b0;
   logic              pwr = 1'b0;
   logic [11:0]       paddr = 12'h000;
   logic [31:0]       pwdata = 32'h0000_0000;
   logic [31:0]       prdata;
   logic              prdy;
   logic              perr;
   logic              irq;
   logic              csel;
   logic [5:0]        pdat;
   logic [31:0]       rd_q;
   dct_pkg::dct_src_s src;
   int                n_errors = 0;
   int                checks_done = 0;
   always #10 clk = ~clk;
   dct_top uut (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(prdy), .pslverr_out(perr), .src_in(src), .irq_out(irq),
      .comparator_select_out(csel), .port_data_out(pdat), .port_oe_n_out());
   dct_src_model src_m (.sys_clk_in(clk), .src_out(src));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      if (n_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // request held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         if (prdy === 1'b1)
            break;
      end
      if (i == 16)
      begin
         n_errors++;
         tally_and_finish();
      end
      rd_q = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
      xfer(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd_q);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(dct_pkg::ADDR_CONTROL, 32'h0000_0000, "control");
      rd(dct_pkg::ADDR_ENABLE, 32'h0000_00C0, "enable");
      wr(dct_pkg::ADDR_ENABLE, 32'h0000_0000);
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0040);
      wr(dct_pkg::ADDR_LOW_CNT, 32'h0000_00FE);
      src_m.pulse(0, 3);
      rd(dct_pkg::ADDR_LOW_CNT, 32'h0000_00FE, "low held");
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0050);
      src_m.pulse(0, 3);
      rd(dct_pkg::ADDR_LOW_CNT, 32'h0000_0001, "low aux");
      rd(dct_pkg::ADDR_CONTROL, 32'h0000_005A, "low carry");
      wr(dct_pkg::ADDR_IRQ_EN, 32'h0000_0001);
      @(negedge clk);
      chk("irq set", 32'h0000_0001, {31'h0, irq});
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0050);
      @(posedge clk);
      chk("irq clear", 32'h0000_0000, {31'h0, irq});
      src_m.set_src(2, 1'b1);
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0020);
      repeat (4) @(posedge clk);
      src_m.pulse(1, 2);
      rd(dct_pkg::ADDR_LOW_CNT, 32'h0000_0003, "low pin gated");
      src_m.set_src(2, 1'b0);
      repeat (6) @(posedge clk);
      rd(dct_pkg::ADDR_CONTROL, 32'h0000_0021, "enable loss");
      chk("irq loss", 32'h0000_0001, {31'h0, irq});
      src_m.set_src(2, 1'b1);
      repeat (6) @(posedge clk);
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0020);
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0000);
      repeat (4) @(posedge clk);
      rd(dct_pkg::ADDR_CONTROL, 32'h0000_0000, "soft disable");
      src_m.set_src(2, 1'b0);
      wr(dct_pkg::ADDR_HIGH_CNT, 32'h0000_00FF);
      src_m.pulse(2, 1);
      rd(dct_pkg::ADDR_HIGH_CNT, 32'h0000_0000, "high pin");
      rd(dct_pkg::ADDR_CONTROL, 32'h0000_0004, "high carry");
      rd(dct_pkg::ADDR_LOW_CNT, 32'h0000_0003, "low apart");
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0040);
      wr(dct_pkg::ADDR_DATA, 32'h0000_00A5);
      @(negedge clk);
      chk("port data", 32'h0000_0025, {26'h000_0000, pdat});
      wr(dct_pkg::ADDR_LOW_CNT, 32'h0000_00FF);
      wr(dct_pkg::ADDR_HIGH_CNT, 32'h0000_00FF);
      wr(dct_pkg::ADDR_ENABLE, 32'h0000_00C0);
      wr(dct_pkg::ADDR_CONTROL, 32'h0000_0050);
      src_m.pulse(0, 1);
      rd(dct_pkg::ADDR_LOW_CNT, 32'h0000_0000, "wide low");
      rd(dct_pkg::ADDR_HIGH_CNT, 32'h0000_0000, "wide high");
      rd(dct_pkg::ADDR_CONTROL, 32'h0000_005C, "wide carry");
      wr(dct_pkg::ADDR_DATA, 32'h0000_00C0);
      @(negedge clk);
      chk("cmp on", 32'h0000_0001, {31'h0, csel});
      wr(dct_pkg::ADDR_DATA, 32'h0000_0080);
      chk("cmp kept", 32'h0000_0001, {31'h0, csel});
      rd(12'h000, 32'h0000_0000, "unmapped");
      tally_and_finish();
   end
endmodule
`default_nettype wire
